//--- rtl/adc_conv_ctrl.sv
// Notes on behaviour
// - After a result load busy rises and the result shifts out on host clock.
// - Host-clocked serial data drives only while chip select low and read/convert high; internal clock mode drives it while busy is low.
// - Frame sync goes high after first host rise for one clock period.
// - MSB follows the second host rise, then one bit per clock.
// - LSB is valid from 17th falling edge through 18th rising edge.
// - Tag bits sampled each clock replay after the LSB, first from 18th fall.
// - With a running clock, tag bits pass until the next result reload.
// - Previous result stays readable for 12 us after a conversion start.
// - Load during an enabled high host clock loses data; host avoids it.
// - Internal clock mode: tag level at first rise follows the 16 bits.
// - Continuous mode converts repeatedly over all channels while pins low.
// - Manual start latches address pins for the following conversion.
// - Start commands are ignored while busy is low.
// - Manual start edges convert the previously latched channel.
// - Continuous start edges restart the sequence on the next channel.
// - Continuous mode drives address pins; busy rise increments the channel.
// - Entering continuous mode starts at last manual address plus one.
// - Idle power-down pulse of 200 ns zeroes channel on its release.
// - Power-down disables analog; continuous next channel resets to zero.
// - Two-bit address is binary, upper pin most significant.
`timescale 1ns/1ps
`include "adc_defines.svh"
module adc_conv_ctrl #(
	parameter int CONV_CYCLES = `ADC_CONV_CYCLES,
	parameter int ACQ_CYCLES = `ADC_ACQ_CYCLES,
	parameter int READ_HOLD_CYCLES = `ADC_READ_HOLD_CYCLES,
	parameter int PD_MIN_CYCLES = `ADC_PD_MIN_CYCLES,
	parameter int INT_HALF_CYCLES = `ADC_INT_HALF_CYCLES,
	parameter int BITS = `ADC_RESULT_BITS
) (
	// System clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Conversion control pins.
	input wire logic cs_n,
	input wire logic read_convert,
	input wire logic power_down,
	input wire logic auto_scan_select,
	input wire logic clock_source_select,
	output logic busy_n,
	// Channel address pins, two-way.
	input wire logic chan_addr_lsb_in,
	input wire logic chan_addr_msb_in,
	output logic chan_addr_lsb_out,
	output logic chan_addr_msb_out,
	output logic chan_addr_oe_n,
	// Analog core.
	input wire logic [BITS-1:0] sample_code,
	output logic [1:0] analog_channel,
	output logic analog_power_on,
	// Serial pins.
	input wire logic serial_bit_clock,
	output logic serial_bit_clock_out,
	output logic serial_bit_clock_oe_n,
	input wire logic tag_in,
	output logic serial_result_out,
	output logic serial_result_oe_n,
	output logic frame_sync
);
	// ==========================================================
	// Pin synchronisers
	adc_pkg::pins_type pins_raw;
	adc_pkg::pins_type pins;
	adc_pkg::pins_type pins_prev;

	assign pins_raw = '{cs_n: cs_n, read_convert: read_convert, power_down: power_down,
		auto_scan_select: auto_scan_select, chan_addr_msb: chan_addr_msb_in,
		chan_addr_lsb: chan_addr_lsb_in, tag_in: tag_in,
		clock_source_select: clock_source_select};

	adc_sync2 #(.WIDTH($bits(adc_pkg::pins_type)), .RESET_VALUE(`ADC_PIN_RESET_VALUE)) u_pin_sync (
		.clk(clk_sys),
		.rst(rst),
		.din(pins_raw),
		.dout(pins)
	);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pins_prev <= `ADC_PIN_RESET_VALUE;
		end else begin
			pins_prev <= pins;
		end
	end

	// ==========================================================
	// Start decode
	adc_pkg::conv_state_type state;
	logic [15:0] conv_cnt;
	logic [15:0] acq_cnt;
	logic [15:0] pd_cnt;
	logic [1:0] next_chan;
	logic chan_zeroed;
	logic [BITS-1:0] result_hold;
	logic load_tog;
	logic load_pulse;

	wire idle = state == adc_pkg::ST_ACQUIRE;
	wire cont = pins.auto_scan_select;
	wire pd = pins.power_down;
	wire rc_fall = pins_prev.read_convert & ~pins.read_convert;
	wire cs_fall = pins_prev.cs_n & ~pins.cs_n;
	wire start_edge = (rc_fall & ~pins.cs_n) | (cs_fall & ~pins.read_convert);
	wire acq_done = acq_cnt >= 16'(ACQ_CYCLES);
	wire auto_run = cont & ~pins.cs_n & ~pins.read_convert & ~pd & acq_done;
	wire start_fire = idle & ~pd & (start_edge | auto_run);
	wire conv_end = ~idle & (conv_cnt == 16'(CONV_CYCLES - 1));
	wire [1:0] addr_pins = {pins.chan_addr_msb, pins.chan_addr_lsb};
	wire cont_enter = cont & ~pins_prev.auto_scan_select;
	wire pd_release = ~pd & pins_prev.power_down & idle & (pd_cnt >= 16'(PD_MIN_CYCLES));
	wire [1:0] chan_step = next_chan + 2'h1;
	wire [15:0] next_conv_cnt = start_fire ? 16'h0000 : conv_cnt + 16'h0001;
	wire [15:0] next_acq_cnt = (!idle || acq_done) ? (idle ? acq_cnt : 16'h0000)
		: acq_cnt + 16'h0001;
	wire [15:0] next_pd_cnt = pd ? ((pd_cnt == 16'hffff) ? pd_cnt : pd_cnt + 16'h0001) : 16'h0000;

	// ==========================================================
	// Channel selection
	logic [1:0] next_next_chan;

	always_comb begin
		next_next_chan = next_chan;
		if (cont && pd) begin
			next_next_chan = 2'h0;
		end else if (pd_release) begin
			next_next_chan = 2'h0;
		end else if (cont_enter && !chan_zeroed) begin
			next_next_chan = chan_step;
		end else if (start_fire && !cont) begin
			next_next_chan = addr_pins;
		end else if (conv_end && cont) begin
			next_next_chan = chan_step;
		end
	end

	// ==========================================================
	// Conversion sequencer
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state <= adc_pkg::ST_ACQUIRE;
			conv_cnt <= 16'h0000;
			acq_cnt <= 16'h0000;
			pd_cnt <= 16'h0000;
			busy_n <= 1'b1;
			analog_channel <= 2'h0;
			result_hold <= '0;
			load_tog <= 1'b0;
			load_pulse <= 1'b0;
		end else begin
			conv_cnt <= next_conv_cnt;
			acq_cnt <= next_acq_cnt;
			pd_cnt <= next_pd_cnt;
			load_pulse <= conv_end;
			unique case (state)
				adc_pkg::ST_ACQUIRE: begin
					if (start_fire) begin
						state <= adc_pkg::ST_CONVERT;
						busy_n <= 1'b0;
						analog_channel <= next_chan;
					end
				end
				adc_pkg::ST_CONVERT: begin
					if (conv_end) begin
						state <= adc_pkg::ST_ACQUIRE;
						busy_n <= 1'b1;
						result_hold <= sample_code;
						load_tog <= ~load_tog;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			next_chan <= 2'h0;
			chan_zeroed <= 1'b0;
			chan_addr_oe_n <= 1'b1;
			analog_power_on <= 1'b0;
		end else begin
			next_chan <= next_next_chan;
			chan_zeroed <= pd_release | (chan_zeroed & ~start_fire);
			chan_addr_oe_n <= ~cont;
			analog_power_on <= ~pd;
		end
	end

	assign chan_addr_msb_out = next_chan[1];
	assign chan_addr_lsb_out = next_chan[0];

	// ==========================================================
	// Internal data clock readout
	// The internal clock runs only during a conversion, so it never disturbs the idle input.
	logic [15:0] half_cnt;
	logic [4:0] int_bits;
	logic int_run;
	logic int_clk;
	logic int_tag;
	logic [BITS-1:0] int_sh;
	logic int_data;
	wire int_mode = ~pins.clock_source_select;
	wire half_tick = int_run & (half_cnt == 16'(INT_HALF_CYCLES - 1));
	wire int_rise = half_tick & ~int_clk;
	wire int_fall = half_tick & int_clk;
	wire int_last = int_fall & (int_bits == 5'(BITS - 1));

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			half_cnt <= 16'h0000;
			int_bits <= 5'h00;
			int_run <= 1'b0;
			int_clk <= 1'b0;
			int_tag <= 1'b0;
			int_sh <= '0;
			int_data <= 1'b0;
		end else if (start_fire && int_mode) begin
			half_cnt <= 16'h0000;
			int_bits <= 5'h00;
			int_run <= 1'b1;
			int_clk <= 1'b0;
			int_sh <= result_hold;
			int_data <= result_hold[BITS-1];
		end else if (half_tick) begin
			half_cnt <= 16'h0000;
			int_clk <= ~int_clk;
			if (int_rise && int_bits == 5'h00) begin
				int_tag <= pins.tag_in;
			end
			if (int_fall) begin
				int_bits <= int_bits + 5'h01;
				int_sh <= {int_sh[BITS-2:0], 1'b0};
				int_data <= int_last ? int_tag : int_sh[BITS-2];
				int_run <= ~int_last;
			end
		end else begin
			half_cnt <= int_run ? half_cnt + 16'h0001 : 16'h0000;
		end
	end

	// ==========================================================
	// Host-clocked readout and pin selection
	logic link_data;
	logic link_oe_n;
	logic link_sync;
	// A fresh result clears the frame at once, because the host clock may be stopped at the load.
	wire link_rst = rst | load_pulse;

	adc_serial_link #(.BITS(BITS)) u_link (
		.serial_bit_clock(serial_bit_clock),
		.rst(link_rst),
		.cs_n(cs_n),
		.read_convert(read_convert),
		.result_hold(result_hold),
		.load_tog(load_tog),
		.tag_in(tag_in),
		.serial_result_out(link_data),
		.serial_result_oe_n(link_oe_n),
		.frame_sync(link_sync)
	);

	// Mode straps are static, so mixing the two readout domains here is glitch free in use.
	assign serial_result_out = int_mode ? int_data : link_data;
	assign serial_result_oe_n = int_mode ? busy_n : link_oe_n;
	assign frame_sync = int_mode ? 1'b0 : link_sync;
	assign serial_bit_clock_out = int_clk;
	assign serial_bit_clock_oe_n = ~int_mode;

	// ==========================================================
	// Checks
	default clocking sys_cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	chk_busy_load: assert property ($rose(busy_n) |-> load_tog != $past(load_tog))
		else $error("busy rose without a result load");
	chk_start_ignored: assert property ((!busy_n && start_edge) |=> $stable(analog_channel))
		else $error("start accepted while busy low");
	chk_manual_latch: assert property ((start_fire && !cont && !pd_release)
		|=> analog_channel == $past(next_chan) && next_chan == $past(addr_pins))
		else $error("manual channel latch wrong");
	chk_scan_step: assert property (($rose(busy_n) && $past(cont) && !$past(pd))
		|-> next_chan == analog_channel + 2'h1)
		else $error("continuous channel did not step");
	chk_addr_drive: assert property (cont ##1 cont |-> !chan_addr_oe_n)
		else $error("address pins not driven in continuous mode");
	chk_pd_zero: assert property ((cont && pd) |=> next_chan == 2'h0)
		else $error("power down did not clear next channel");
	chk_pd_release: assert property (pd_release |=> next_chan == 2'h0 && chan_zeroed)
		else $error("power down release did not zero channel");
	chk_result_hold: assert property ((!idle && conv_cnt < 16'(READ_HOLD_CYCLES))
		|=> $stable(result_hold))
		else $error("previous result lost early");
	chk_auto_start: assert property ((idle && auto_run && !pd) |=> !busy_n)
		else $error("continuous mode did not start");
	chk_scan_entry: assert property ((cont_enter && !chan_zeroed && !pd)
		|=> next_chan == $past(chan_step))
		else $error("continuous entry channel wrong");
	chk_int_tag: assert property (int_last |=> int_data == $past(int_tag))
		else $error("tag level not after sixteen bits");
	cov_manual_conv: cover property (start_fire && !cont);
	cov_cont_conv: cover property (start_fire && cont ##1 !busy_n);
	cov_pd_zero: cover property (pd_release);
	cov_int_frame: cover property (int_last);
endmodule : adc_conv_ctrl

//--- inc/adc_defines.svh
`ifndef ADC_DEFINES_SVH
`define ADC_DEFINES_SVH

// ==========================================================
// Clock and result geometry
`define ADC_CLK_PERIOD_NS 50
`define ADC_RESULT_BITS 16

// ==========================================================
// Conversion timing, in ns and in system clock cycles
`define ADC_CONV_TIME_NS 20000
`define ADC_CONV_CYCLES ((`ADC_CONV_TIME_NS + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS)
`define ADC_ACQ_TIME_NS 5000
`define ADC_ACQ_CYCLES ((`ADC_ACQ_TIME_NS + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS)
`define ADC_READ_HOLD_NS 12000
`define ADC_READ_HOLD_CYCLES (`ADC_READ_HOLD_NS / `ADC_CLK_PERIOD_NS)
`define ADC_PD_MIN_NS 200
`define ADC_PD_MIN_CYCLES ((`ADC_PD_MIN_NS + `ADC_CLK_PERIOD_NS - 1) / `ADC_CLK_PERIOD_NS)
`define ADC_INT_HALF_NS 500
`define ADC_INT_HALF_CYCLES (`ADC_INT_HALF_NS / `ADC_CLK_PERIOD_NS)

// ==========================================================
// Host-clocked frame positions, counted in rising edges, and pin synchroniser reset value
`define ADC_RELOAD_GUARD 3
`define ADC_PIN_RESET_VALUE 8'h80

`endif

//--- inc/adc_pkg.sv
package adc_pkg;

	// ==========================================================
	// Types
	typedef enum logic {
		ST_ACQUIRE,
		ST_CONVERT
	} conv_state_type;

	typedef struct packed {
		logic cs_n;
		logic read_convert;
		logic power_down;
		logic auto_scan_select;
		logic chan_addr_msb;
		logic chan_addr_lsb;
		logic tag_in;
		logic clock_source_select;
	} pins_type;

endpackage : adc_pkg

//--- rtl/adc_sync2.sv
`timescale 1ns/1ps
module adc_sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Data.
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stage1 <= RESET_VALUE;
			dout <= RESET_VALUE;
		end else begin
			stage1 <= din;
			dout <= stage1;
		end
	end
endmodule : adc_sync2

//--- rtl/adc_serial_link.sv
`timescale 1ns/1ps
`include "adc_defines.svh"
module adc_serial_link #(
	parameter int BITS = `ADC_RESULT_BITS
) (
	// Link clock and resets.
	input wire logic serial_bit_clock,
	input wire logic rst,
	// Frame enable pins.
	input wire logic cs_n,
	input wire logic read_convert,
	// Result from the conversion side.
	input wire logic [BITS-1:0] result_hold,
	input wire logic load_tog,
	// Serial pins.
	input wire logic tag_in,
	output logic serial_result_out,
	output logic serial_result_oe_n,
	output logic frame_sync
);
	// ==========================================================
	// Frame state
	// Leaving the read window clears the frame, so a stopped clock needs no edge to end it.
	wire frame_rst = rst | cs_n | ~read_convert;
	logic [4:0] cnt;
	logic [BITS:0] sh;
	logic seen;
	logic tog_sync;
	wire settled = cnt >= 5'(`ADC_RELOAD_GUARD);
	wire reload = settled & (tog_sync != seen);
	wire [4:0] next_cnt = (cnt == 5'h1f) ? cnt : cnt + 5'h01;

	adc_sync2 #(.WIDTH(1), .RESET_VALUE(1'b0)) u_tog_sync (
		.clk(serial_bit_clock),
		.rst(frame_rst),
		.din(load_tog),
		.dout(tog_sync)
	);

	assign serial_result_oe_n = frame_rst;

	always_ff @(posedge serial_bit_clock or posedge frame_rst) begin
		if (frame_rst) begin
			cnt <= 5'h00;
			sh <= '0;
			seen <= 1'b0;
			frame_sync <= 1'b0;
			serial_result_out <= 1'b0;
		end else if (cnt == 5'h00 || reload) begin
			cnt <= 5'h01;
			sh <= {result_hold, tag_in};
			seen <= tog_sync;
			frame_sync <= 1'b1;
		end else begin
			cnt <= next_cnt;
			if (!settled) begin
				seen <= tog_sync;
			end
			frame_sync <= 1'b0;
			serial_result_out <= sh[BITS];
			sh <= {sh[BITS-1:0], tag_in};
		end
	end

	// ==========================================================
	// Checks
	logic [BITS-1:0] frame_word;
	logic first_tag;

	always_ff @(posedge serial_bit_clock or posedge frame_rst) begin
		if (frame_rst) begin
			frame_word <= '0;
			first_tag <= 1'b0;
		end else if (cnt == 5'h00 || reload) begin
			frame_word <= result_hold;
			first_tag <= tag_in;
		end
	end

	default clocking link_cb @(posedge serial_bit_clock);
	endclocking
	default disable iff (frame_rst);

	chk_sync_one_period: assert property ((cnt == 5'h00) |=> frame_sync ##1 !frame_sync)
		else $error("frame sync not one link clock wide");
	chk_msb_first: assert property ((cnt == 5'h01 && !reload) |=> serial_result_out == frame_word[BITS-1])
		else $error("msb not after second rise");
	chk_lsb_slot: assert property ((cnt == 5'h10 && !reload) |=> serial_result_out == frame_word[0])
		else $error("lsb not after seventeenth rise");
	chk_tag_replay: assert property ((cnt == 5'h11 && !reload) |=> serial_result_out == first_tag)
		else $error("first tag bit not after result");
	chk_reload_restart: assert property (reload |=> frame_sync && cnt == 5'h01)
		else $error("reload did not restart frame");
	cov_full_frame: cover property (cnt == 5'h12);
	cov_reload: cover property (reload);
endmodule : adc_serial_link

//--- dv/host_model.sv
`timescale 1ns/1ps
// ==========================================================
// Host controller: starts conversions and clocks results out.
module host_model (
	// System clock, used only to pace pin changes.
	input wire logic clk_sys,
	// Device serial outputs.
	input wire logic serial_result_out,
	input wire logic serial_result_oe_n,
	input wire logic frame_sync,
	// Host-driven pins.
	output logic cs_n,
	output logic read_convert,
	output logic serial_bit_clock,
	output logic tag_in
);
	initial begin
		cs_n = 1'b1;
		read_convert = 1'b1;
		serial_bit_clock = 1'b0;
		tag_in = 1'b0;
	end

	// ==========================================================
	// Pin changes
	task automatic set_pins(input logic c, input logic r);
		@(negedge clk_sys);
		cs_n = c;
		read_convert = r;
	endtask : set_pins

	// The convert pulse lasts two system clocks, then read_convert returns high.
	task automatic start_conv();
		set_pins(1'b0, 1'b0);
		repeat (2) @(negedge clk_sys);
		read_convert = 1'b1;
	endtask : start_conv

	// ==========================================================
	// Readout frame
	// The clock idles low between frames, so a result load never meets it high.
	// A line that is not driven reads back inverted, never as its last value.
	task automatic read_frame(input logic [21:0] tpat, output logic [21:0] w,
		output logic [21:0] s);
		w = '0;
		s = '0;
		@(negedge clk_sys);
		cs_n = 1'b0;
		read_convert = 1'b1;
		#30;
		for (int k = 0; k < 22; k++) begin
			tag_in = tpat[21 - k];
			#3.75 serial_bit_clock = 1'b1;
			#7.5 serial_bit_clock = 1'b0;
			s = {s[20:0], frame_sync};
			w = {w[20:0], serial_result_oe_n ? ~serial_result_out : serial_result_out};
			#3.75;
		end
	endtask : read_frame

endmodule : host_model

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	// ==========================================================
	// Setup: counts are shortened so each conversion takes 40 cycles.
	localparam int CONV = 40;
	localparam logic [21:0] TPAT = 22'h35a5a1;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic power_down = 1'b0;
	logic auto_scan_select = 1'b0;
	logic clock_source_select = 1'b1;
	logic [1:0] addr_drv = 2'h0;
	logic [15:0] sample_code = 16'h0000;
	logic cs_n, read_convert, host_clk, tag_in, busy_n;
	logic a_lsb_out, a_msb_out, a_oe_n, clk_out, clk_oe_n;
	logic sro, sro_oe_n, frame_sync, analog_power_on;
	logic [1:0] analog_channel;
	wire logic a_lsb = a_oe_n ? addr_drv[0] : a_lsb_out;
	wire logic a_msb = a_oe_n ? addr_drv[1] : a_msb_out;
	wire logic sbc = clk_oe_n ? host_clk : clk_out;
	int error_cnt = 0;
	int n_checks = 0;
	int low_cnt = 0;
	int low_len = 0;
	logic [15:0] int_word = 16'h0000;

	always #25 clk_sys = ~clk_sys;

	adc_conv_ctrl #(.CONV_CYCLES(CONV), .ACQ_CYCLES(10), .READ_HOLD_CYCLES(24),
		.PD_MIN_CYCLES(2), .INT_HALF_CYCLES(1)) u_adc_conv_ctrl (
		.clk_sys(clk_sys), .rst(rst), .cs_n(cs_n), .read_convert(read_convert),
		.power_down(power_down), .auto_scan_select(auto_scan_select),
		.clock_source_select(clock_source_select), .busy_n(busy_n),
		.chan_addr_lsb_in(a_lsb), .chan_addr_msb_in(a_msb),
		.chan_addr_lsb_out(a_lsb_out), .chan_addr_msb_out(a_msb_out),
		.chan_addr_oe_n(a_oe_n), .sample_code(sample_code),
		.analog_channel(analog_channel), .analog_power_on(analog_power_on),
		.serial_bit_clock(sbc), .serial_bit_clock_out(clk_out),
		.serial_bit_clock_oe_n(clk_oe_n), .tag_in(tag_in),
		.serial_result_out(sro), .serial_result_oe_n(sro_oe_n),
		.frame_sync(frame_sync));

	host_model u_host_model (
		.clk_sys(clk_sys), .serial_result_out(sro), .serial_result_oe_n(sro_oe_n),
		.frame_sync(frame_sync), .cs_n(cs_n), .read_convert(read_convert),
		.serial_bit_clock(host_clk), .tag_in(tag_in));

	// Length of the last low phase of busy_n, in system clocks.
	always @(posedge clk_sys) begin
		if (busy_n === 1'b0) begin
			low_cnt++;
		end else begin
			if (low_cnt != 0) low_len = low_cnt;
			low_cnt = 0;
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wait_busy(input logic lvl);
		int cyc;
		cyc = 0;
		while (busy_n !== lvl && cyc < 500) begin
			@(negedge clk_sys);
			cyc++;
		end
		@(negedge clk_sys);
		check(32'(busy_n), 32'(lvl));
	endtask : wait_busy

	task automatic frame(input logic [15:0] exp);
		logic [21:0] w;
		logic [21:0] s;
		u_host_model.read_frame(TPAT, w, s);
		check(32'(w[20:5]), 32'(exp));
		check(32'(w[4:0]), 32'(TPAT[21:17]));
		check(32'(s), 32'h200000);
		check(32'(sro_oe_n), 32'h0);
	endtask : frame

	task automatic wrap_up();
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up

	// Eight conversions are run; this limit leaves a wide margin.
	initial begin
		#200000;
		error_cnt++;
		wrap_up();
	end

	// ==========================================================
	// Tests
	initial begin
		repeat (5) @(negedge clk_sys);
		rst = 1'b0;
		repeat (2) @(negedge clk_sys);
		check(32'(sro_oe_n), 32'h1);
		check(32'(a_oe_n), 32'h1);
		addr_drv = 2'h2;
		sample_code = 16'ha5c3;
		u_host_model.start_conv();
		wait_busy(1'b0);
		check(32'(analog_channel), 32'h0);
		u_host_model.start_conv();
		wait_busy(1'b1);
		check(32'(low_len), 32'(CONV));
		frame(16'ha5c3);
		u_host_model.set_pins(1'b1, 1'b1);
		@(negedge clk_sys);
		check(32'(sro_oe_n), 32'h1);
		$display("test manual done");

		addr_drv = 2'h1;
		sample_code = 16'h3c5a;
		u_host_model.start_conv();
		wait_busy(1'b0);
		check(32'(analog_channel), 32'h2);
		frame(16'ha5c3);
		wait_busy(1'b1);
		frame(16'h3c5a);
		$display("test overlap done");

		u_host_model.set_pins(1'b1, 1'b1);
		auto_scan_select = 1'b1;
		repeat (4) @(negedge clk_sys);
		check(32'(a_oe_n), 32'h0);
		u_host_model.set_pins(1'b0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			wait_busy(1'b0);
			check(32'(analog_channel), 32'((i + 2) % 4));
			wait_busy(1'b1);
			check(32'({a_msb, a_lsb}), 32'((i + 3) % 4));
			check(32'(low_len), 32'(CONV));
		end
		u_host_model.set_pins(1'b1, 1'b1);
		repeat (20) @(negedge clk_sys);
		check(32'(busy_n), 32'h1);
		$display("test continuous done");

		power_down = 1'b1;
		repeat (4) @(negedge clk_sys);
		check(32'(analog_power_on), 32'h0);
		check(32'({a_msb, a_lsb}), 32'h0);
		power_down = 1'b0;
		repeat (12) @(negedge clk_sys);
		check(32'(analog_power_on), 32'h1);
		u_host_model.set_pins(1'b0, 1'b0);
		wait_busy(1'b0);
		check(32'(analog_channel), 32'h0);
		wait_busy(1'b1);
		check(32'({a_msb, a_lsb}), 32'h1);
		u_host_model.set_pins(1'b1, 1'b1);
		$display("test power down done");

		auto_scan_select = 1'b0;
		clock_source_select = 1'b0;
		u_host_model.tag_in = 1'b1;
		repeat (4) @(negedge clk_sys);
		check(32'(clk_oe_n), 32'h0);
		u_host_model.start_conv();
		for (int k = 0; k < 16; k++) begin
			@(posedge sbc);
			@(negedge clk_sys);
			int_word = {int_word[14:0], sro};
		end
		check(32'(int_word), 32'h3c5a);
		repeat (2) @(negedge clk_sys);
		check(32'(sro), 32'h1);
		check(32'(clk_out), 32'h0);
		wait_busy(1'b1);
		clock_source_select = 1'b1;
		u_host_model.set_pins(1'b1, 1'b1);
		$display("test internal clock done");
		wrap_up();
	end

endmodule : testbench
